// ### frlp_pkg.sv
// constants, types and register map of the flash row latch programmer
// assumes a single 50 MHz clock and a byte-wide register port
package frlp_pkg;

    // -------------------------------------------------------------------
    // register offsets
    // -------------------------------------------------------------------
    localparam logic [3:0] REG_ADDR_LOW   = 4'h0;
    localparam logic [3:0] REG_ADDR_HIGH  = 4'h1;
    localparam logic [3:0] REG_DATA_LOW   = 4'h2;
    localparam logic [3:0] REG_DATA_HIGH  = 4'h3;
    localparam logic [3:0] REG_CONTROL    = 4'h4;
    localparam logic [3:0] REG_UNLOCK_KEY = 4'h5;
    localparam logic [3:0] REG_IRQ_STATUS = 4'h6;
    localparam logic [3:0] REG_IRQ_MASK   = 4'h7;

    // -------------------------------------------------------------------
    // field positions
    // -------------------------------------------------------------------
    localparam int CTL_START_BIT  = 0;
    localparam int CTL_ARM_BIT    = 1;
    localparam int CTL_ERR_BIT    = 2;
    localparam int CTL_ERASE_BIT  = 3;
    localparam int CTL_LONLY_BIT  = 4;
    localparam int CTL_CFG_BIT    = 5;
    localparam int IRQ_DONE_BIT   = 0;
    localparam int IRQ_ERR_BIT    = 1;

    // -------------------------------------------------------------------
    // reset values and keys
    // -------------------------------------------------------------------
    localparam logic [7:0]  ADDR_LOW_RESET  = 8'h00;
    localparam logic [6:0]  ADDR_HIGH_RESET = 7'h00;
    localparam logic [7:0]  DATA_LOW_RESET  = 8'h00;
    localparam logic [5:0]  DATA_HIGH_RESET = 6'h00;
    localparam logic [1:0]  IRQ_RESET       = 2'h0;
    localparam logic [7:0]  KEY_FIRST       = 8'h55;
    localparam logic [7:0]  KEY_SECOND      = 8'haa;
    localparam logic [13:0] LATCH_BLANK     = 14'h3fff;
    localparam int          LATCH_COUNT     = 32;

    // -------------------------------------------------------------------
    // timing
    // -------------------------------------------------------------------
    localparam int          CLOCK_MHZ     = 50;
    localparam int          PROG_TIME_NS  = 2000;
    localparam int          ERASE_TIME_NS = 2000;
    localparam logic [11:0] PROG_WAIT_CYCLES  = 12'((PROG_TIME_NS * CLOCK_MHZ + 999) / 1000);
    localparam logic [11:0] ERASE_WAIT_CYCLES = 12'((ERASE_TIME_NS * CLOCK_MHZ + 999) / 1000);

    // -------------------------------------------------------------------
    // types
    // -------------------------------------------------------------------
    typedef enum logic [2:0] {
        UNL_IDLE  = 3'b001,
        UNL_FIRST = 3'b010,
        UNL_ARMED = 3'b100
    } frlp_unl_t;

    typedef enum logic [3:0] {
        OP_IDLE  = 4'b0001,
        OP_PROG  = 4'b0010,
        OP_WAIT  = 4'b0100,
        OP_ERASE = 4'b1000
    } frlp_op_t;

    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } frlp_bus_req_t;

    typedef struct packed {
        logic        word_we;
        logic        row_erase;
        logic        cfg_space;
        logic [9:0]  row;
        logic [4:0]  col;
        logic [13:0] word;
    } frlp_flash_cmd_t;

endpackage

// ### frlp_props.sv
// checker of the flash row latch programmer: port-level timing relations
// assumes it is bound into frlp_top and sees only that module's ports
`timescale 1ns/1ps

module frlp_props (
    input wire logic                      clock,
    input wire logic                      rst,
    input wire frlp_pkg::frlp_bus_req_t   bus_req,
    input wire logic [7:0]                reg_rdata,
    input wire logic                      write_protect,
    input wire frlp_pkg::frlp_flash_cmd_t flash_cmd,
    input wire logic                      cpu_stall,
    input wire logic                      irq
);
    import frlp_pkg::*;

    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    // -------------------------------------------------------------------
    // length of the current word write burst
    // -------------------------------------------------------------------
    logic [5:0] we_run_r;
    logic [5:0] we_run_nxt;

    always_comb begin
        we_run_nxt = flash_cmd.word_we ? we_run_r + 6'h01 : 6'h00;
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            we_run_r <= 6'h00;
        end else begin
            we_run_r <= we_run_nxt;
        end
    end

    // -------------------------------------------------------------------
    // properties
    // -------------------------------------------------------------------
    property p_burst_full;
        $fell(flash_cmd.word_we) |-> we_run_r == 6'd32;
    endproperty
    a_burst_full: assert property (p_burst_full) else $error("burst not 32 words");
    property p_col_first;
        $rose(flash_cmd.word_we) |-> flash_cmd.col == 5'h00;
    endproperty
    a_col_first: assert property (p_col_first) else $error("burst not at word 0");
    property p_col_step;
        flash_cmd.word_we && $past(flash_cmd.word_we) |-> flash_cmd.col == $past(flash_cmd.col) + 5'h01;
    endproperty
    a_col_step: assert property (p_col_step) else $error("word index skipped");
    property p_row_hold;
        flash_cmd.word_we && $past(flash_cmd.word_we) |-> $stable(flash_cmd.row);
    endproperty
    a_row_hold: assert property (p_row_hold) else $error("row moved in burst");
    property p_no_auto_erase;
        flash_cmd.word_we |-> !flash_cmd.row_erase && cpu_stall;
    endproperty
    a_no_auto_erase: assert property (p_no_auto_erase) else $error("erase in program");
    property p_erase_pulse;
        flash_cmd.row_erase |-> cpu_stall ##1 !flash_cmd.row_erase && !flash_cmd.word_we;
    endproperty
    a_erase_pulse: assert property (p_erase_pulse) else $error("erase not one pulse");
    property p_unlock;
        $rose(cpu_stall) |-> $past(bus_req.wr) && $past(bus_req.addr) == REG_CONTROL
            && $past(bus_req.wdata[CTL_START_BIT]) && $past(bus_req.wdata, 2) == KEY_SECOND
            && $past(bus_req.addr, 2) == REG_UNLOCK_KEY && $past(bus_req.wdata, 3) == KEY_FIRST;
    endproperty
    a_unlock: assert property (p_unlock) else $error("start without unlock");
    property p_stall_end;
        $rose(cpu_stall) |-> ##[1:300] !cpu_stall;
    endproperty
    a_stall_end: assert property (p_stall_end) else $error("stall never ends");

    c_prog: cover property ($fell(flash_cmd.word_we));
    c_erase: cover property (flash_cmd.row_erase);
    c_irq: cover property ($rose(irq));

endmodule // frlp_props

bind frlp_top frlp_props i_props (
    .clock(clock), .rst(rst), .bus_req(bus_req), .reg_rdata(reg_rdata),
    .write_protect(write_protect), .flash_cmd(flash_cmd), .cpu_stall(cpu_stall), .irq(irq)
);

// ### frlp_top.sv
// flash row latch programmer: unlock guard, 32 row latches, program/erase sequencer
// assumes the flash array takes one word write per cycle and an erase pulse per row
// assumes the core leaves the bus idle while cpu_stall is high; such writes are dropped, except writes that clear irq status bits
`timescale 1ns/1ps

module frlp_top (
    input  wire logic                    clock,
    input  wire logic                    rst,
    input  wire frlp_pkg::frlp_bus_req_t bus_req,
    output logic [7:0]                   reg_rdata,
    input  wire logic                    write_protect,
    output frlp_pkg::frlp_flash_cmd_t    flash_cmd,
    output logic                         cpu_stall,
    output logic                         irq
);
    import frlp_pkg::*;

    // -------------------------------------------------------------------
    // state
    // -------------------------------------------------------------------
    logic [7:0]        addr_low_r,  addr_low_nxt;
    logic [6:0]        addr_high_r, addr_high_nxt;
    logic [7:0]        data_low_r,  data_low_nxt;
    logic [5:0]        data_high_r, data_high_nxt;

    logic              start_r,     start_nxt;
    logic              arm_r,       arm_nxt;
    logic              err_r,       err_nxt;
    logic              erase_r,     erase_nxt;
    logic              lonly_r,     lonly_nxt;
    logic              cfg_r,       cfg_nxt;

    frlp_unl_t         unl_r,       unl_nxt;
    frlp_op_t          op_r,        op_nxt;
    logic [4:0]        wcnt_r,      wcnt_nxt;
    logic [11:0]       wait_r,      wait_nxt;

    logic [1:0]        ist_r,       ist_nxt;
    logic [1:0]        imask_r,     imask_nxt;
    logic              irq_r,       irq_nxt;

    logic              stall_r,     stall_nxt;
    logic [7:0]        rdata_r,     rdata_nxt;
    frlp_flash_cmd_t   cmd_r,       cmd_nxt;

    logic [13:0]       latch_r [LATCH_COUNT];
    logic [13:0]       latch_nxt [LATCH_COUNT];

    logic              wp_meta_r;
    logic              wp_sync_r;

    logic              wr_hit;
    logic              go;
    logic              clear_latches;
    logic              load_latch;
    logic              set_err;
    logic              set_done;
    logic [9:0]        row_sel;
    logic [4:0]        col_sel;

    // -------------------------------------------------------------------
    // address decode
    // -------------------------------------------------------------------
    function automatic logic hit(input frlp_bus_req_t req, input logic [3:0] offs);
        hit = req.wr && (req.addr == offs);
    endfunction

    assign row_sel = {addr_high_r[6:0], addr_low_r[7:5]};
    assign col_sel = addr_low_r[4:0];

    // -------------------------------------------------------------------
    // write protect input synchroniser
    // -------------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (rst) begin
            wp_meta_r <= 1'b0;
            wp_sync_r <= 1'b0;
        end else begin
            wp_meta_r <= write_protect;
            wp_sync_r <= wp_meta_r;
        end
    end

    // -------------------------------------------------------------------
    // registers, unlock guard and operation sequencer
    // -------------------------------------------------------------------
    always_comb begin
        addr_low_nxt  = addr_low_r;
        addr_high_nxt = addr_high_r;
        data_low_nxt  = data_low_r;
        data_high_nxt = data_high_r;
        start_nxt     = start_r;
        arm_nxt       = arm_r;
        err_nxt       = err_r;
        erase_nxt     = erase_r;
        lonly_nxt     = lonly_r;
        cfg_nxt       = cfg_r;
        unl_nxt       = unl_r;
        op_nxt        = op_r;
        wcnt_nxt      = wcnt_r;
        wait_nxt      = wait_r;
        imask_nxt     = imask_r;
        go            = 1'b0;
        clear_latches = 1'b0;
        load_latch    = 1'b0;
        set_err       = 1'b0;
        set_done      = 1'b0;
        cmd_nxt       = '0;
        cmd_nxt.cfg_space = cfg_r;
        cmd_nxt.row       = row_sel;
        cmd_nxt.col       = col_sel;
        wr_hit        = bus_req.wr && (op_r == OP_IDLE);

        // plain register writes; the core is stalled while busy
        if (wr_hit) begin
            if (hit(bus_req, REG_ADDR_LOW)) begin
                addr_low_nxt = bus_req.wdata;
            end else if (hit(bus_req, REG_ADDR_HIGH)) begin
                addr_high_nxt = bus_req.wdata[6:0];
            end else if (hit(bus_req, REG_DATA_LOW)) begin
                data_low_nxt = bus_req.wdata;
            end else if (hit(bus_req, REG_DATA_HIGH)) begin
                data_high_nxt = bus_req.wdata[5:0];
            end else if (hit(bus_req, REG_CONTROL)) begin
                arm_nxt   = bus_req.wdata[CTL_ARM_BIT];
                err_nxt   = bus_req.wdata[CTL_ERR_BIT];
                erase_nxt = bus_req.wdata[CTL_ERASE_BIT];
                lonly_nxt = bus_req.wdata[CTL_LONLY_BIT];
                cfg_nxt   = bus_req.wdata[CTL_CFG_BIT];
            end else if (hit(bus_req, REG_IRQ_MASK)) begin
                imask_nxt = bus_req.wdata[1:0];
            end
        end

        // unlock guard: 55h, aah, then start, with no other write between
        if (wr_hit) begin
            case (unl_r)
                UNL_IDLE: begin
                    if (hit(bus_req, REG_UNLOCK_KEY) && bus_req.wdata == KEY_FIRST) begin
                        unl_nxt = UNL_FIRST;
                    end
                end
                UNL_FIRST: begin
                    if (hit(bus_req, REG_UNLOCK_KEY) && bus_req.wdata == KEY_SECOND) begin
                        unl_nxt = UNL_ARMED;
                    end else begin
                        unl_nxt = UNL_IDLE;
                        set_err = 1'b1;
                    end
                end
                UNL_ARMED: begin
                    unl_nxt = UNL_IDLE;
                    // the start write must carry the arm bit itself
                    if (hit(bus_req, REG_CONTROL) && bus_req.wdata[CTL_START_BIT]
                        && bus_req.wdata[CTL_ARM_BIT]) begin
                        go = 1'b1;
                    end else begin
                        set_err = 1'b1;
                    end
                end
                default: begin
                    unl_nxt = UNL_IDLE;
                end
            endcase
        end

        // start of an operation, using the control value just written
        if (go) begin
            if (bus_req.wdata[CTL_ERASE_BIT]) begin
                if (wp_sync_r) begin
                    set_err = 1'b1;
                end else begin
                    start_nxt         = 1'b1;
                    op_nxt            = OP_ERASE;
                    wait_nxt          = ERASE_WAIT_CYCLES;
                    cmd_nxt.row_erase = 1'b1;
                end
            end else if (bus_req.wdata[CTL_LONLY_BIT]) begin
                load_latch = 1'b1;
            end else if (wp_sync_r) begin
                set_err = 1'b1;
            end else begin
                start_nxt = 1'b1;
                op_nxt    = OP_PROG;
                wcnt_nxt  = 5'h00;
            end
        end

        // sequencer
        case (op_r)
            OP_PROG: begin
                // one latch word per cycle; the counter doubles as the column
                cmd_nxt.word_we = 1'b1;
                cmd_nxt.col     = wcnt_r;
                cmd_nxt.word    = latch_r[wcnt_r];
                wcnt_nxt        = wcnt_r + 5'h01;
                if (wcnt_r == 5'(LATCH_COUNT - 1)) begin
                    op_nxt   = OP_WAIT;
                    wait_nxt = PROG_WAIT_CYCLES;
                end
            end
            OP_WAIT, OP_ERASE: begin
                wait_nxt = wait_r - 12'h001;
                if (wait_r == 12'h001) begin
                    op_nxt        = OP_IDLE;
                    start_nxt     = 1'b0;
                    clear_latches = 1'b1;
                    set_done      = 1'b1;
                end
            end
            default: begin
            end
        endcase

        if (set_err) begin
            err_nxt = 1'b1;
        end
    end

    // -------------------------------------------------------------------
    // row latches
    // -------------------------------------------------------------------
    generate
        for (genvar i = 0; i < LATCH_COUNT; i++) begin : g_latch
            always_comb begin
                latch_nxt[i] = latch_r[i];
                if (clear_latches) begin
                    latch_nxt[i] = LATCH_BLANK;
                end else if (load_latch && col_sel == 5'(i)) begin
                    latch_nxt[i] = {data_high_r[5:0], data_low_r};
                end
            end

            always_ff @(posedge clock) begin
                if (rst) begin
                    latch_r[i] <= LATCH_BLANK;
                end else begin
                    latch_r[i] <= latch_nxt[i];
                end
            end
        end
    endgenerate

    // -------------------------------------------------------------------
    // interrupt, stall and read data
    // -------------------------------------------------------------------
    always_comb begin
        ist_nxt = ist_r;
        if (bus_req.wr && bus_req.addr == REG_IRQ_STATUS) begin
            ist_nxt = ist_r & ~bus_req.wdata[1:0];
        end
        // a new event wins over a software clear in the same cycle
        ist_nxt[IRQ_DONE_BIT] = ist_nxt[IRQ_DONE_BIT] | set_done;
        ist_nxt[IRQ_ERR_BIT]  = ist_nxt[IRQ_ERR_BIT] | set_err;
        irq_nxt   = |(ist_nxt & imask_nxt);
        stall_nxt = (op_nxt != OP_IDLE);
        rdata_nxt = 8'h00;
        if (bus_req.rd) begin
            if (bus_req.addr == REG_ADDR_LOW) begin
                rdata_nxt = addr_low_r;
            end else if (bus_req.addr == REG_ADDR_HIGH) begin
                rdata_nxt = {1'b0, addr_high_r};
            end else if (bus_req.addr == REG_DATA_LOW) begin
                rdata_nxt = data_low_r;
            end else if (bus_req.addr == REG_DATA_HIGH) begin
                rdata_nxt = {2'b00, data_high_r};
            end else if (bus_req.addr == REG_CONTROL) begin
                rdata_nxt = {2'b00, cfg_r, lonly_r, erase_r, err_r, arm_r, start_r};
            end else if (bus_req.addr == REG_IRQ_STATUS) begin
                rdata_nxt = {6'h00, ist_r};
            end else if (bus_req.addr == REG_IRQ_MASK) begin
                rdata_nxt = {6'h00, imask_r};
            end
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            ist_r   <= IRQ_RESET;
            irq_r   <= 1'b0;
            stall_r <= 1'b0;
            rdata_r <= 8'h00;
        end else begin
            ist_r   <= ist_nxt;
            irq_r   <= irq_nxt;
            stall_r <= stall_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    // -------------------------------------------------------------------
    // register update of the register file, unlock guard and sequencer
    // -------------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (rst) begin
            addr_low_r  <= ADDR_LOW_RESET;
            addr_high_r <= ADDR_HIGH_RESET;
            data_low_r  <= DATA_LOW_RESET;
            data_high_r <= DATA_HIGH_RESET;
            start_r     <= 1'b0;
            arm_r       <= 1'b0;
            // a one-cycle reset that cuts an operation leaves the error flag for software; a longer reset clears it
            err_r       <= (op_r != OP_IDLE);
            erase_r     <= 1'b0;
            lonly_r     <= 1'b0;
            cfg_r       <= 1'b0;
            unl_r       <= UNL_IDLE;
            op_r        <= OP_IDLE;
            wcnt_r      <= 5'h00;
            wait_r      <= 12'h000;
            imask_r     <= IRQ_RESET;
            cmd_r       <= '0;
        end else begin
            addr_low_r  <= addr_low_nxt;
            addr_high_r <= addr_high_nxt;
            data_low_r  <= data_low_nxt;
            data_high_r <= data_high_nxt;
            start_r     <= start_nxt;
            arm_r       <= arm_nxt;
            err_r       <= err_nxt;
            erase_r     <= erase_nxt;
            lonly_r     <= lonly_nxt;
            cfg_r       <= cfg_nxt;
            unl_r       <= unl_nxt;
            op_r        <= op_nxt;
            wcnt_r      <= wcnt_nxt;
            wait_r      <= wait_nxt;
            imask_r     <= imask_nxt;
            cmd_r       <= cmd_nxt;
        end
    end

    // -------------------------------------------------------------------
    // outputs
    // -------------------------------------------------------------------
    assign reg_rdata = rdata_r;
    assign flash_cmd = cmd_r;
    assign cpu_stall = stall_r;
    assign irq       = irq_r;

endmodule // frlp_top

// ### testbench.sv
// self-checking bench of the flash row latch programmer
// assumes frlp_top with the register map and timing of frlp_pkg
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin n_checks++; if ((got) !== (ex)) begin fails++; \
    $display("[ERR] %s expected %h seen %h", nm, ex, got); end end

module testbench;
    import frlp_pkg::*;

    logic            clock;
    logic            rst;
    frlp_bus_req_t   bus_req;
    logic [7:0]      reg_rdata;
    logic            write_protect;
    frlp_flash_cmd_t flash_cmd;
    logic            cpu_stall;
    logic            irq;
    int              fails;
    int              n_checks;
    int              n_we;
    int              n_er;
    logic [13:0]     cap [32];
    logic [9:0]      cap_row;

    frlp_top i_dut (.clock(clock), .rst(rst), .bus_req(bus_req), .reg_rdata(reg_rdata),
        .write_protect(write_protect), .flash_cmd(flash_cmd), .cpu_stall(cpu_stall), .irq(irq));

    // -------------------------------------------------------------------
    // bus tasks and flash-side capture
    // -------------------------------------------------------------------
    always @(posedge clock) begin
        if (flash_cmd.word_we === 1'b1) begin
            cap[flash_cmd.col] <= flash_cmd.word;
            cap_row <= flash_cmd.row;
            n_we++;
        end
        if (flash_cmd.row_erase === 1'b1) n_er++;
    end

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clock);
        bus_req <= '{a, d, 1'b1, 1'b0};
    endtask

    task automatic idle();
        @(posedge clock);
        bus_req <= '0;
        #1;
    endtask

    task automatic rd(input logic [3:0] a, input logic [7:0] ex, input string nm);
        @(posedge clock);
        bus_req <= '{a, 8'h00, 1'b0, 1'b1};
        @(posedge clock);
        bus_req <= '0;
        #1;
        `CHK(nm, ex, reg_rdata)
    endtask

    task automatic unlock(input logic [7:0] ctl);
        wr(REG_UNLOCK_KEY, KEY_FIRST);
        wr(REG_UNLOCK_KEY, KEY_SECOND);
        wr(REG_CONTROL, ctl);
        idle();
    endtask

    task automatic load(input logic [7:0] al, input logic [7:0] dh, input logic [7:0] dl);
        wr(REG_ADDR_LOW, al);
        wr(REG_DATA_LOW, dl);
        wr(REG_DATA_HIGH, dh);
        unlock(8'h13);
        `CHK("load stall", 1'b0, cpu_stall)
    endtask

    task automatic run_op(input logic [7:0] ctl);
        int k;
        n_we = 0;
        n_er = 0;
        unlock(ctl);
        `CHK("op stall", 1'b1, cpu_stall)
        k = 0;
        do begin
            @(posedge clock);
            #1;
            k++;
        end while (cpu_stall !== 1'b0 && k < 400);
        `CHK("op done", 1'b1, k < 400)
    endtask

    task automatic prog_blank();
        run_op(8'h03);
        for (int i = 0; i < 32; i++) `CHK("blank word", LATCH_BLANK, cap[i])
    endtask

    // -------------------------------------------------------------------
    // scenarios
    // -------------------------------------------------------------------
    task automatic t_reset_map();
        rd(REG_CONTROL, 8'h00, "ctl reset");
        rd(REG_UNLOCK_KEY, 8'h00, "key read");
        for (int a = 8; a < 16; a++) rd(4'(a), 8'h00, "unmapped");
    endtask

    task automatic t_load_prog();
        wr(REG_ADDR_HIGH, 8'hda);
        load(8'hb3, 8'hc5, 8'h21);
        load(8'hbf, 8'h3f, 8'hfe);
        `CHK("load no write", 0, n_we)
        rd(REG_CONTROL, 8'h12, "ctl after load");
        run_op(8'h03);
        `CHK("word count", 32, n_we)
        `CHK("no erase", 0, n_er)
        `CHK("row", 10'h2d5, cap_row)
        `CHK("word 19", 14'h0521, cap[19])
        `CHK("word 31", 14'h3ffe, cap[31])
        `CHK("word 0", LATCH_BLANK, cap[0])
        rd(REG_CONTROL, 8'h02, "start cleared");
        rd(REG_IRQ_STATUS, 8'h01, "done status");
        `CHK("irq masked", 1'b0, irq)
        wr(REG_IRQ_MASK, 8'h03);
        idle();
        @(posedge clock);
        #1;
        `CHK("irq raised", 1'b1, irq)
        wr(REG_IRQ_STATUS, 8'h01);
        idle();
        @(posedge clock);
        #1;
        `CHK("irq cleared", 1'b0, irq)
        prog_blank();
    endtask

    task automatic t_erase();
        load(8'ha0, 8'h12, 8'h34);
        run_op(8'h0b);
        `CHK("erase pulses", 1, n_er)
        `CHK("erase writes", 0, n_we)
        prog_blank();
    endtask

    task automatic t_broken();
        n_we = 0;
        n_er = 0;
        wr(REG_UNLOCK_KEY, KEY_FIRST);
        wr(REG_ADDR_LOW, 8'ha0);
        idle();
        rd(REG_CONTROL, 8'h06, "broken error");
        rd(REG_IRQ_STATUS, 8'h03, "error status");
        wr(REG_UNLOCK_KEY, KEY_SECOND);
        wr(REG_CONTROL, 8'h03);
        idle();
        `CHK("broken stall", 1'b0, cpu_stall)
        wr(REG_CONTROL, 8'h02);
        wr(REG_IRQ_STATUS, 8'h03);
        idle();
        @(posedge clock);
        write_protect <= 1'b1;
        repeat (2) @(posedge clock);
        unlock(8'h03);
        `CHK("protect stall", 1'b0, cpu_stall)
        rd(REG_CONTROL, 8'h06, "protect error");
        unlock(8'h0b);
        `CHK("protect erase stall", 1'b0, cpu_stall)
        rd(REG_CONTROL, 8'h0e, "protect erase error");
        @(posedge clock);
        write_protect <= 1'b0;
        `CHK("no writes", 0, n_we)
        `CHK("protect no erase", 0, n_er)
    endtask

    task automatic t_space();
        wr(REG_CONTROL, 8'h22);
        idle();
        repeat (2) @(posedge clock);
        #1;
        `CHK("cfg space", 1'b1, flash_cmd.cfg_space)
        wr(REG_CONTROL, 8'h02);
        idle();
        repeat (2) @(posedge clock);
        #1;
        `CHK("flash space", 1'b0, flash_cmd.cfg_space)
    endtask

    task automatic end_sim();
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end

    initial begin
        #200000;
        fails++;
        end_sim();
    end

    initial begin
        rst = 1'b1;
        bus_req = '0;
        write_protect = 1'b0;
        repeat (10) @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
        t_reset_map();
        t_load_prog();
        t_erase();
        t_broken();
        t_space();
        end_sim();
    end

endmodule // testbench
